// [logic/cdc_regs.svh]
`ifndef CDC_REGS_SVH
`define CDC_REGS_SVH
// Register byte offsets
`define CDC_OFS_CTRL_A   8'h00
`define CDC_OFS_CTRL_B   8'h04
`define CDC_OFS_RESULT   8'h08
`define CDC_OFS_FLAG     8'h0C
// Control A fields
`define CDC_A_ENABLE     7
`define CDC_A_STATUS     6
`define CDC_A_PIN_OE     5
`define CDC_A_INVERT     4
`define CDC_A_SPEED      2
`define CDC_A_HYST       1
`define CDC_A_SYNC       0
// Control B fields
`define CDC_B_RISE       7
`define CDC_B_FALL       6
`define CDC_B_POS_LSB    4
`define CDC_B_NEG_LSB    0
// Flag register fields
`define CDC_F_FLAG       0
`define CDC_F_IRQ_EN     1
// Reset values and response codes
`define CDC_SPEED_RST    1'b1
`define CDC_RESP_OKAY    2'h0
`define CDC_RESP_SLVERR  2'h2
`endif

// [logic/cdc_pkg.sv]
// Purpose: types shared by the comparator digital control
// Assumes: one comparator instance per block
// Notes:   field positions live in cdc_regs.svh
package cdc_pkg;
    typedef enum logic [1:0] {
        CDC_POS_PIN    = 2'h0,
        CDC_POS_DAC    = 2'h1,
        CDC_POS_FIXREF = 2'h2,
        CDC_POS_GND    = 2'h3
    } cdc_pos_src_t;

    typedef struct packed {
        logic comparator_enable;
        logic pin_output_enable;
        logic output_invert;
        logic speed_select;
        logic hysteresis_enable;
        logic timer_sync_enable;
    } cdc_ctrl_a_t;

    typedef struct packed {
        logic         rise_edge_enable;
        logic         fall_edge_enable;
        cdc_pos_src_t positive_channel_select;
        logic [1:0]   negative_channel_select;
    } cdc_ctrl_b_t;

    typedef struct packed {
        logic       enable;
        logic       speed;
        logic       hysteresis;
        logic       connect;
        logic [1:0] pos_sel;
        logic [1:0] neg_sel;
    } cdc_analog_t;
endpackage

// [logic/cdc_comparator_ctrl.sv]
// Purpose: digital control around one analog comparator, AXI4-Lite registers
// Assumes: all inputs synchronous to sys_clk_i; timer clocks sampled as data
// Notes:   pin, gate and shutdown outputs are registered one cycle
`timescale 1ns/100ps
`include "cdc_regs.svh"
module cdc_comparator_ctrl #(
    parameter int ADDR_W = 8                        // AXI address width
) (
    input  wire logic                sys_clk_i,      // 100 MHz clock
    input  wire logic                reset_n_i,      // Async reset, low
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,   // Write address
    input  wire logic                s_axi_awvalid,  // Write address valid
    output logic                     s_axi_awready,  // Write address ready
    input  wire logic [31:0]         s_axi_wdata,    // Write data
    input  wire logic [3:0]          s_axi_wstrb,    // Write strobes
    input  wire logic                s_axi_wvalid,   // Write data valid
    output logic                     s_axi_wready,   // Write data ready
    output logic [1:0]               s_axi_bresp,    // Write response
    output logic                     s_axi_bvalid,   // Write response valid
    input  wire logic                s_axi_bready,   // Write response ready
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,   // Read address
    input  wire logic                s_axi_arvalid,  // Read address valid
    output logic                     s_axi_arready,  // Read address ready
    output logic [31:0]              s_axi_rdata,    // Read data
    output logic [1:0]               s_axi_rresp,    // Read response
    output logic                     s_axi_rvalid,   // Read data valid
    input  wire logic                s_axi_rready,   // Read data ready
    input  wire logic                cmp_raw_i,      // Analog core: vp above vn
    input  wire logic                tmr_src_clk_i,  // Timer source clock
    input  wire logic                tmr_pre_clk_i,  // Timer prescaled clock
    input  wire logic                tmr_pre_used_i, // Timer prescaler in use
    input  wire logic                pin_dir_in_i,   // Pin direction bit, 1 = input
    input  wire logic                port_data_i,    // Port data latch
    output cdc_pkg::cdc_analog_t     analog_o,       // Analog core controls
    output logic                     pin_out_o,      // Output pin value
    output logic                     pin_oe_o,       // Output pin drive enable
    output logic                     tmr_gate_o,     // Timer gate source
    output logic                     pwm_shutdown_o, // PWM shutdown input
    output logic                     change_flag_o,  // Change flag level
    output logic                     change_irq_o    // Flag gated by its enable
);
    // ============================================================
    // Parameter check
    // ============================================================
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W out of range");
    end

    // ============================================================
    // Registers and result path
    // ============================================================
    cdc_pkg::cdc_ctrl_a_t ctrl_a_reg;
    cdc_pkg::cdc_ctrl_b_t ctrl_b_reg;
    logic                 change_flag_reg;
    logic                 irq_en_reg;
    logic                 tclk_prev_reg;
    logic                 sync_reg;
    logic                 result_reg;
    logic                 result_prev_reg;
    logic                 cmp_val;
    logic                 tclk_sel;
    logic                 tclk_fall;
    logic                 result_next;
    logic                 rise_hit;
    logic                 fall_hit;
    logic                 edge_hit;

    // Disabled core reads as low before invert, so toggling invert, or enable while cmp_raw_i is high, shows an edge
    assign cmp_val     = (ctrl_a_reg.comparator_enable & cmp_raw_i)
                         ^ ctrl_a_reg.output_invert;
    assign tclk_sel    = tmr_pre_used_i ? tmr_pre_clk_i : tmr_src_clk_i;
    assign tclk_fall   = tclk_prev_reg & ~tclk_sel;
    assign result_next = ctrl_a_reg.timer_sync_enable ? sync_reg : cmp_val;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tclk_prev_reg <= 1'b0;
            sync_reg      <= 1'b0;
        end else begin
            tclk_prev_reg <= tclk_sel;
            if (tclk_fall) begin
                sync_reg <= cmp_val;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_reg      <= 1'b0;
            result_prev_reg <= 1'b0;
        end else begin
            result_reg      <= result_next;
            result_prev_reg <= result_reg;
        end
    end

    assign rise_hit = result_reg & ~result_prev_reg & ctrl_b_reg.rise_edge_enable;
    assign fall_hit = ~result_reg & result_prev_reg & ctrl_b_reg.fall_edge_enable;
    assign edge_hit = rise_hit | fall_hit;

    // ============================================================
    // Outputs to pin, timer, PWM and analog core
    // ============================================================
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_out_o      <= 1'b0;
            pin_oe_o       <= 1'b0;
            tmr_gate_o     <= 1'b0;
            pwm_shutdown_o <= 1'b0;
            change_irq_o   <= 1'b0;
            analog_o       <= '0;
        end else begin
            // Override of the port latch ignores the enable bit
            pin_out_o      <= ctrl_a_reg.pin_output_enable ? result_next
                                                           : port_data_i;
            pin_oe_o       <= ~pin_dir_in_i;
            tmr_gate_o     <= result_next;
            pwm_shutdown_o <= result_next;
            change_irq_o   <= change_flag_reg & irq_en_reg;
            analog_o.enable     <= ctrl_a_reg.comparator_enable;
            analog_o.speed      <= ctrl_a_reg.speed_select;
            analog_o.hysteresis <= ctrl_a_reg.hysteresis_enable;
            analog_o.connect    <= ctrl_a_reg.comparator_enable;
            analog_o.pos_sel    <= ctrl_b_reg.positive_channel_select;
            analog_o.neg_sel    <= ctrl_b_reg.negative_channel_select;
        end
    end
    assign change_flag_o = change_flag_reg;

    // ============================================================
    // AXI4-Lite slave
    // ============================================================
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic              wstrb0_reg;
    logic              wr_go;
    logic              wr_hit;
    logic              flag_clear;
    logic [7:0]        wr_ofs;
    logic [7:0]        rd_ofs;
    logic [31:0]       rd_word;
    logic              rd_hit;
    logic              aw_held_next;
    logic              w_held_next;
    logic              bvalid_next;
    logic              rvalid_next;

    assign wr_go         = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign aw_held_next  = ~wr_go & (aw_held_reg | (s_axi_awvalid & s_axi_awready));
    assign w_held_next   = ~wr_go & (w_held_reg | (s_axi_wvalid & s_axi_wready));
    assign bvalid_next   = wr_go | (s_axi_bvalid & ~s_axi_bready);
    assign rvalid_next   = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);

    // Ready flops load the function of next state that a gate would give,
    // so outputs come from flops and the handshake timing is unchanged
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_awready <= ~aw_held_next & ~bvalid_next;
            s_axi_wready  <= ~w_held_next & ~bvalid_next;
            s_axi_arready <= ~rvalid_next;
        end
    end
    assign wr_ofs        = 8'(awaddr_reg);
    assign wr_hit        = (wr_ofs == `CDC_OFS_CTRL_A) | (wr_ofs == `CDC_OFS_CTRL_B)
                         | (wr_ofs == `CDC_OFS_RESULT) | (wr_ofs == `CDC_OFS_FLAG);
    assign flag_clear    = wr_go & wstrb0_reg & (wr_ofs == `CDC_OFS_FLAG)
                         & wdata_reg[`CDC_F_FLAG];

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= '0;
            wdata_reg    <= 32'h0000_0000;
            wstrb0_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CDC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `CDC_RESP_OKAY : `CDC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_a_reg <= '{speed_select: `CDC_SPEED_RST, default: 1'b0};
            ctrl_b_reg <= '0;
            irq_en_reg <= 1'b0;
        end else if (wr_go && wstrb0_reg) begin
            unique case (wr_ofs)
                `CDC_OFS_CTRL_A: begin
                    ctrl_a_reg.comparator_enable <= wdata_reg[`CDC_A_ENABLE];
                    ctrl_a_reg.pin_output_enable <= wdata_reg[`CDC_A_PIN_OE];
                    ctrl_a_reg.output_invert     <= wdata_reg[`CDC_A_INVERT];
                    ctrl_a_reg.speed_select      <= wdata_reg[`CDC_A_SPEED];
                    ctrl_a_reg.hysteresis_enable <= wdata_reg[`CDC_A_HYST];
                    ctrl_a_reg.timer_sync_enable <= wdata_reg[`CDC_A_SYNC];
                end
                `CDC_OFS_CTRL_B: begin
                    ctrl_b_reg.rise_edge_enable <= wdata_reg[`CDC_B_RISE];
                    ctrl_b_reg.fall_edge_enable <= wdata_reg[`CDC_B_FALL];
                    ctrl_b_reg.positive_channel_select <=
                        cdc_pkg::cdc_pos_src_t'(wdata_reg[`CDC_B_POS_LSB +: 2]);
                    ctrl_b_reg.negative_channel_select <= wdata_reg[`CDC_B_NEG_LSB +: 2];
                end
                `CDC_OFS_FLAG: begin
                    irq_en_reg <= wdata_reg[`CDC_F_IRQ_EN];
                end
                default: begin
                end
            endcase
        end
    end

    // Set beats clear so an edge during the clearing write is kept
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            change_flag_reg <= 1'b0;
        end else if (edge_hit) begin
            change_flag_reg <= 1'b1;
        end else if (flag_clear) begin
            change_flag_reg <= 1'b0;
        end
    end

    assign rd_ofs = 8'(s_axi_araddr);
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (rd_ofs)
            `CDC_OFS_CTRL_A: begin
                rd_word[`CDC_A_ENABLE] = ctrl_a_reg.comparator_enable;
                rd_word[`CDC_A_STATUS] = result_reg;
                rd_word[`CDC_A_PIN_OE] = ctrl_a_reg.pin_output_enable;
                rd_word[`CDC_A_INVERT] = ctrl_a_reg.output_invert;
                rd_word[`CDC_A_SPEED]  = ctrl_a_reg.speed_select;
                rd_word[`CDC_A_HYST]   = ctrl_a_reg.hysteresis_enable;
                rd_word[`CDC_A_SYNC]   = ctrl_a_reg.timer_sync_enable;
            end
            `CDC_OFS_CTRL_B: begin
                rd_word[`CDC_B_RISE]          = ctrl_b_reg.rise_edge_enable;
                rd_word[`CDC_B_FALL]          = ctrl_b_reg.fall_edge_enable;
                rd_word[`CDC_B_POS_LSB +: 2]  = ctrl_b_reg.positive_channel_select;
                rd_word[`CDC_B_NEG_LSB +: 2]  = ctrl_b_reg.negative_channel_select;
            end
            `CDC_OFS_RESULT: rd_word[0] = result_reg;
            `CDC_OFS_FLAG: begin
                rd_word[`CDC_F_FLAG]   = change_flag_reg;
                rd_word[`CDC_F_IRQ_EN] = irq_en_reg;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `CDC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `CDC_RESP_OKAY : `CDC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ============================================================
    // Assertions
    // ============================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence edge_seen_s;
        edge_hit;
    endsequence
    sequence clear_write_s;
        flag_clear;
    endsequence

    raw_polarity_a: assert property (
        ctrl_a_reg.comparator_enable && !ctrl_a_reg.timer_sync_enable
        |=> result_reg == ($past(cmp_raw_i) ^ $past(ctrl_a_reg.output_invert)))
        else $error("result does not follow raw input and polarity");
    enable_drive_a: assert property (
        ##1 analog_o.enable == $past(ctrl_a_reg.comparator_enable)
            && analog_o.connect == $past(ctrl_a_reg.comparator_enable))
        else $error("analog enable or connect wrong");
    status_mirror_a: assert property (
        s_axi_arvalid && s_axi_arready && rd_ofs == `CDC_OFS_RESULT
        |=> s_axi_rdata[0] == $past(result_reg))
        else $error("mirror bit wrong");
    pin_override_a: assert property (
        ##1 pin_out_o == ($past(ctrl_a_reg.pin_output_enable)
                          ? $past(result_next) : $past(port_data_i)))
        else $error("pin override wrong");
    pin_dir_a: assert property (
        ##1 pin_oe_o == !$past(pin_dir_in_i))
        else $error("pin drive enable wrong");
    sync_hold_a: assert property (
        ctrl_a_reg.timer_sync_enable && !tclk_fall ##1 ctrl_a_reg.timer_sync_enable
        |-> $stable(sync_reg))
        else $error("sync value moved off a falling edge");
    gate_same_a: assert property (
        ##1 tmr_gate_o == pwm_shutdown_o && tmr_gate_o == result_reg)
        else $error("gate, shutdown and status differ");
    edge_flag_a: assert property (
        edge_seen_s |=> change_flag_reg)
        else $error("enabled edge did not set flag");
    clear_race_a: assert property (
        clear_write_s and edge_seen_s |=> change_flag_reg)
        else $error("flag lost during clear");
    clear_works_a: assert property (
        clear_write_s and !edge_hit |=> !change_flag_reg)
        else $error("flag not cleared");
    speed_reset_a: assert property (
        $rose(reset_n_i) |-> ctrl_a_reg.speed_select)
        else $error("speed select reset value wrong");
    bresp_bound_a: assert property (
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");
    ready_flop_a: assert property (
        s_axi_arready == !s_axi_rvalid && s_axi_awready == (!aw_held_reg && !s_axi_bvalid))
        else $error("ready flops out of step");
endmodule // cdc_comparator_ctrl

// [verification/cdc_analog_model.sv]
// Purpose: behavioural analog comparator core with input routing
// Assumes: levels in millivolts, all negative pins share one level
// Notes:   output churns while disabled, so an ungated result shows up
`timescale 1ns/100ps
module cdc_analog_model #(
    parameter int DAC_MV = 500,                 // DAC level
    parameter int FIX_MV = 1024                 // Fixed reference level
) (
    input  wire logic                 sys_clk_i, // Clock
    input  wire cdc_pkg::cdc_analog_t analog_i,  // Core controls
    input  int                        vp_mv_i,   // Positive pin level
    input  int                        vn_mv_i,   // Negative pin level
    output logic                      raw_o      // Comparison result
);
    int   vp;
    logic raw_q = 1'b0;
    assign raw_o = raw_q;
    always_comb begin
        case (analog_i.pos_sel)
            2'h0: vp = vp_mv_i;
            2'h1: vp = DAC_MV;
            2'h2: vp = FIX_MV;
            default: vp = 0;
        endcase
    end
    // Disconnected inputs give no valid answer
    always @(posedge sys_clk_i) begin
        if (!(analog_i.enable && analog_i.connect)) begin
            raw_q <= !raw_q;
        end else if (!analog_i.hysteresis || vp > vn_mv_i + 10 || vn_mv_i > vp + 10) begin
            raw_q <= vp > vn_mv_i;
        end
    end
endmodule // cdc_analog_model

// [verification/comparator_digital_control_tb.sv]
// Purpose: self-checking bench for the comparator control block
// Assumes: offsets 0x00 ctrl_a, 0x04 ctrl_b, 0x08 result, 0x0C flag
// Notes:   timer clocks are driven as plain data
`timescale 1ns/100ps
module comparator_digital_control_tb;
    logic        sys_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, raw, src_clk, pre_clk, pre_used;
    logic        dir_in, port_data, pin_out, pin_oe, gate, pwm, flag, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          vp, vn, errors, samples_checked, cycles;
    cdc_pkg::cdc_analog_t analog;

    cdc_comparator_ctrl dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_raw_i(raw),
        .tmr_src_clk_i(src_clk), .tmr_pre_clk_i(pre_clk), .tmr_pre_used_i(pre_used),
        .pin_dir_in_i(dir_in), .port_data_i(port_data), .analog_o(analog),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe), .tmr_gate_o(gate),
        .pwm_shutdown_o(pwm), .change_flag_o(flag), .change_irq_o(irq));
    cdc_analog_model model_u (.sys_clk_i(sys_clk), .analog_i(analog), .vp_mv_i(vp),
        .vn_mv_i(vn), .raw_o(raw));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Whole run needs a few hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end
    // ==========================================
    // Checks and bus cycles
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge sys_clk);
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (!bvalid);
        chk(bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid);
        chk(rdata, ed);
        chk(rresp, er);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(8'h00, 32'h04, 2'h0);
        chk(analog.speed, 1'b1);
        chk(analog.enable, 1'b0);
        chk(analog.connect, 1'b0);
        rd(8'h10, 32'h00, 2'h2);
        axw(8'h10, 32'hFF, 2'h2);
        $display("t_reset done");
    endtask
    task automatic t_result();
        axw(8'h00, 32'h84, 2'h0);
        cyc(3);
        rd(8'h00, 32'hC4, 2'h0);
        rd(8'h08, 32'h01, 2'h0);
        chk(gate, 1'b1);
        chk(pwm, 1'b1);
        chk(analog.connect, 1'b1);
        vp <= 600;
        cyc(3);
        chk(gate, 1'b0);
        axw(8'h00, 32'h94, 2'h0);
        cyc(3);
        chk(gate, 1'b1);
        rd(8'h00, 32'hD4, 2'h0);
        axw(8'h00, 32'h82, 2'h0);
        cyc(1);
        chk(analog.speed, 1'b0);
        chk(analog.hysteresis, 1'b1);
        axw(8'h00, 32'h80, 2'h0);
        vp <= 800;
        $display("t_result done");
    endtask
    task automatic t_chan();
        logic [3:0] exp;
        exp = 4'h5;
        for (int i = 0; i < 4; i++) begin
            axw(8'h04, 32'(i * 17), 2'h0);
            cyc(3);
            chk(analog.pos_sel, i);
            chk(analog.neg_sel, i);
            chk(gate, exp[i]);
        end
        axw(8'h04, 32'h00, 2'h0);
        $display("t_chan done");
    endtask
    task automatic t_edge();
        axw(8'h00, 32'h84, 2'h0);
        vp <= 600;
        cyc(3);
        axw(8'h0C, 32'h03, 2'h0);
        axw(8'h04, 32'h80, 2'h0);
        vp <= 800;
        cyc(5);
        chk(flag, 1'b1);
        chk(irq, 1'b1);
        axw(8'h0C, 32'h03, 2'h0);
        chk(flag, 1'b0);
        vp <= 600;
        cyc(4);
        chk(flag, 1'b0);
        axw(8'h04, 32'h40, 2'h0);
        axw(8'h00, 32'h14, 2'h0);
        cyc(3);
        chk(flag, 1'b0);
        chk(gate, 1'b1);
        axw(8'h00, 32'h04, 2'h0);
        cyc(3);
        chk(flag, 1'b1);
        axw(8'h0C, 32'h01, 2'h0);
        cyc(2);
        chk(irq, 1'b0);
        vp <= 800;
        axw(8'h00, 32'h84, 2'h0);
        cyc(3);
        axw(8'h0C, 32'h01, 2'h0);
        chk(flag, 1'b0);
        vp <= 600;
        cyc(1);
        axw(8'h0C, 32'h01, 2'h0);
        chk(flag, 1'b1);
        $display("t_edge done");
    endtask
    task automatic t_pin();
        vp <= 800;
        dir_in <= 1'b0;
        port_data <= 1'b0;
        axw(8'h00, 32'hA4, 2'h0);
        cyc(3);
        chk(pin_oe, 1'b1);
        chk(pin_out, 1'b1);
        port_data <= 1'b1;
        axw(8'h00, 32'h24, 2'h0);
        cyc(3);
        chk(pin_out, 1'b0);
        axw(8'h00, 32'h04, 2'h0);
        cyc(3);
        chk(pin_out, 1'b1);
        dir_in <= 1'b1;
        cyc(3);
        chk(pin_oe, 1'b0);
        $display("t_pin done");
    endtask
    task automatic t_sync();
        vp <= 600;
        axw(8'h00, 32'h85, 2'h0);
        cyc(3);
        src_clk <= 1'b0;
        cyc(3);
        src_clk <= 1'b1;
        vp <= 800;
        cyc(5);
        chk(gate, 1'b0);
        src_clk <= 1'b0;
        cyc(4);
        chk(gate, 1'b1);
        pre_used <= 1'b1;
        vp <= 600;
        cyc(2);
        src_clk <= 1'b1;
        cyc(2);
        src_clk <= 1'b0;
        cyc(4);
        chk(gate, 1'b1);
        pre_clk <= 1'b0;
        cyc(4);
        chk(gate, 1'b0);
        $display("t_sync done");
    endtask

    initial begin
        reset_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        {src_clk, pre_clk, pre_used, port_data} = 4'hC;
        dir_in = 1'b1;
        vp = 800;
        vn = 700;
        cyc(4);
        reset_n <= 1'b1;
        cyc(1);
        t_reset();
        t_result();
        t_chan();
        t_edge();
        t_pin();
        t_sync();
        test_done();
    end
endmodule // comparator_digital_control_tb
